// ==== include/scd_pkg.sv ====
// Constants and types shared by the chain diagnostic status bank
package scd_pkg;
    // Register word addresses
    localparam logic [15:0] ADDR_ERR_FLAGS   = 16'h0000;
    localparam logic [15:0] ADDR_GUARD_LOW   = 16'h0001;
    localparam logic [15:0] ADDR_GUARD_HIGH  = 16'h0002;
    localparam logic [15:0] ADDR_FAULT_POS   = 16'h0003;
    localparam logic [15:0] ADDR_CFG_COUNT   = 16'h0004;
    localparam logic [15:0] NUM_WORDS        = 16'h0005;
    localparam logic [15:0] WORD_RESET       = 16'h0000;

    // Field positions in the error word
    localparam int ERR_LOOP_ABSENT_BIT = 4;
    localparam int ERR_TOO_MANY_BIT    = 3;
    localparam int ERR_MISMATCH_BIT    = 2;
    localparam int ERR_FAIL_BIT        = 1;
    localparam int ERR_CONTACT_BIT     = 0;

    // Chain geometry
    localparam int             MAX_SWITCHES   = 20;
    localparam int             LOW_SWITCHES   = 16;
    localparam int             HIGH_SWITCHES  = 4;
    localparam logic [5:0]     MAX_SWITCHES_6 = 6'h14;

    // Request function and exception codes
    localparam logic [7:0]  FUNC_READ_HOLDING = 8'h03;
    localparam logic [7:0]  EXC_BAD_FUNC      = 8'h01;
    localparam logic [7:0]  EXC_BAD_ADDR      = 8'h02;
    localparam logic [7:0]  EXC_BAD_QTY       = 8'h03;
    localparam logic [15:0] QTY_MAX           = 16'h007d;

    // Initialization phase timing
    localparam longint CLOCK_HZ        = 125000000;
    localparam longint INIT_TIME_S     = 5;
    localparam int     INIT_CYCLES     = int'(INIT_TIME_S * CLOCK_HZ);
    localparam int     INIT_CNT_W      = 32;

    typedef enum logic [1:0] {
        SCD_INIT,
        SCD_IDLE,
        SCD_SEND
    } scd_state_t;
endpackage : scd_pkg

// ==== rtl/scd_sync.sv ====
// Two-flop synchroniser bank for chain-side pin inputs
`timescale 1ns/10ps
`default_nettype none
module scd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // One pair of flops per bit; first flop feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= async_i[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    assign sync_o = sync_reg;
endmodule : scd_sync
`default_nettype wire

// ==== rtl/scd_status_regs.sv ====
// Chain diagnostic status words with a read-holding-registers request port
//
// How it works
// - Five read-only 16-bit status words sit at word addresses 0 to 4, word n at address n.
// - Error bit 4 is one while the loopback terminator is seen absent and zero otherwise.
// - Error bit 3 is one while more than twenty switches are seen in the chain.
// - Error bit 2 is one when the seen count or the live setting differs from the setting taken at start.
// - Error bit 1 is one on a failed switch, a cable break or an invalid transponder.
// - Error bit 0 shows the chain error contact, one when closed and zero when open.
// - Word 1 bit k gives the guard state of switch k+1 and reads zero in error mode.
// - Word 2 bits 3..0 give switches 17..20, upper bits zero, whole word zero in error mode.
// - Word 3 bits 4..0 give the position of a break or failed switch, upper bits zero.
// - Word 4 bits 4..0 give the switch count from the micro-switches, upper bits zero.
// - Only the read-holding-registers function is answered, anything else gets an exception.
// - Once the contact opens on an error it stays open until the next reset.
// - A five-second start phase runs after reset before any word is reported or request taken.
`timescale 1ns/10ps
`default_nettype none
module scd_status_regs
    import scd_pkg::*;
#(
    parameter int INIT_LEN = scd_pkg::INIT_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    // Chain-side pins, asynchronous
    input  wire logic        loop_absent_i,
    input  wire logic [5:0]  seen_count_i,
    input  wire logic        switch_fail_i,
    input  wire logic        cable_break_i,
    input  wire logic        bad_transponder_i,
    input  wire logic [4:0]  fault_pos_i,
    input  wire logic [19:0] guard_closed_i,
    input  wire logic [4:0]  dip_count_i,
    // Request port, same clock
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_func_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [15:0] req_qty_i,
    output logic             req_ready_o,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_data_o,
    output logic             rsp_last_o,
    output logic             rsp_exc_o,
    output logic [7:0]       rsp_exc_code_o,
    // Chain error contact and phase
    output logic             contact_closed_o,
    output logic             init_busy_o
);
    import scd_pkg::*;

    localparam int SYNC_W = 1 + 6 + 3 + 5 + 20 + 5;

    typedef struct packed {
        scd_state_t         state;
        logic [INIT_CNT_W-1:0] init_cnt;
        logic [4:0]         cfg_count;
        logic               contact_latched_open;
        logic               contact_closed;
        logic [15:0]        w_err;
        logic [15:0]        w_low;
        logic [15:0]        w_high;
        logic [15:0]        w_pos;
        logic [15:0]        w_cfg;
        logic [15:0]        rd_addr;
        logic [15:0]        rd_left;
        logic               req_ready;
        logic               rsp_valid;
        logic [15:0]        rsp_data;
        logic               rsp_last;
        logic               rsp_exc;
        logic [7:0]         rsp_exc_code;
        logic               init_busy;
    } scd_regs_t;

    scd_regs_t st_reg;
    scd_regs_t st_next;

    logic [SYNC_W-1:0] pins_sync;
    logic              loop_absent_s;
    logic [5:0]        seen_count_s;
    logic              fail_s;
    logic              break_s;
    logic              transp_s;
    logic [4:0]        fault_pos_s;
    logic [19:0]       guard_s;
    logic [4:0]        dip_s;

    // Pins pass two flops before use
    scd_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .async_i ({loop_absent_i, seen_count_i, switch_fail_i, cable_break_i,
                   bad_transponder_i, fault_pos_i, guard_closed_i, dip_count_i}),
        .sync_o  (pins_sync)
    );

    assign {loop_absent_s, seen_count_s, fail_s, break_s, transp_s,
            fault_pos_s, guard_s, dip_s} = pins_sync;

    // Error conditions from the synchronised chain view
    logic err_loop;
    logic err_many;
    logic err_mismatch;
    logic err_fail;
    logic err_any;

    always_comb begin
        err_loop     = loop_absent_s;
        err_many     = seen_count_s > MAX_SWITCHES_6;
        err_mismatch = (seen_count_s != {1'b0, st_reg.cfg_count})
                     || (dip_s != st_reg.cfg_count);
        err_fail     = fail_s | break_s | transp_s;
        err_any      = err_loop | err_many | err_mismatch | err_fail;
    end

    // Word read mux for the sender
    function automatic logic [15:0] word_at(input scd_regs_t s, input logic [15:0] a);
        case (a)
            ADDR_ERR_FLAGS:  word_at = s.w_err;
            ADDR_GUARD_LOW:  word_at = s.w_low;
            ADDR_GUARD_HIGH: word_at = s.w_high;
            ADDR_FAULT_POS:  word_at = s.w_pos;
            ADDR_CFG_COUNT:  word_at = s.w_cfg;
            default:         word_at = WORD_RESET;
        endcase
    endfunction : word_at

    // Next-state logic
    always_comb begin
        st_next           = st_reg;
        st_next.rsp_valid = 1'b0;
        st_next.rsp_last  = 1'b0;
        st_next.rsp_exc   = 1'b0;
        st_next.rsp_data  = WORD_RESET;

        if (st_reg.state != SCD_INIT) begin
            // Status words refresh every cycle after the start phase
            st_next.w_err = WORD_RESET;
            st_next.w_err[ERR_LOOP_ABSENT_BIT] = err_loop;
            st_next.w_err[ERR_TOO_MANY_BIT]    = err_many;
            st_next.w_err[ERR_MISMATCH_BIT]    = err_mismatch;
            st_next.w_err[ERR_FAIL_BIT]        = err_fail;
            st_next.w_err[ERR_CONTACT_BIT]     = st_reg.contact_closed;
            st_next.w_low  = err_any ? WORD_RESET
                           : guard_s[LOW_SWITCHES-1:0];
            st_next.w_high = err_any ? WORD_RESET
                           : {12'h000, guard_s[MAX_SWITCHES-1:LOW_SWITCHES]};
            st_next.w_pos  = err_fail ? {11'h000, fault_pos_s}
                           : WORD_RESET;
            st_next.w_cfg  = {11'h000, st_reg.cfg_count};
            // Contact opens on error and stays open
            if (err_any) begin
                st_next.contact_latched_open = 1'b1;
            end
            st_next.contact_closed = !err_any && !st_reg.contact_latched_open;
        end

        case (st_reg.state)
            SCD_INIT: begin
                st_next.contact_closed = 1'b0;
                st_next.req_ready      = 1'b0;
                if (st_reg.init_cnt >= INIT_CNT_W'(INIT_LEN - 1)) begin
                    st_next.state     = SCD_IDLE;
                    st_next.cfg_count = dip_s;
                    st_next.req_ready = 1'b1;
                end else begin
                    st_next.init_cnt = st_reg.init_cnt + INIT_CNT_W'(1);
                end
            end
            SCD_IDLE: begin
                if (req_valid_i) begin
                    st_next.req_ready = 1'b0;
                    if (req_func_i != FUNC_READ_HOLDING) begin
                        st_next.rsp_valid    = 1'b1;
                        st_next.rsp_last     = 1'b1;
                        st_next.rsp_exc      = 1'b1;
                        st_next.rsp_exc_code = EXC_BAD_FUNC;
                        st_next.req_ready    = 1'b1;
                    end else if (req_qty_i == 16'h0000 || req_qty_i > QTY_MAX) begin
                        st_next.rsp_valid    = 1'b1;
                        st_next.rsp_last     = 1'b1;
                        st_next.rsp_exc      = 1'b1;
                        st_next.rsp_exc_code = EXC_BAD_QTY;
                        st_next.req_ready    = 1'b1;
                    end else if ({1'b0, req_addr_i} + {1'b0, req_qty_i}
                                 > {1'b0, NUM_WORDS}) begin
                        st_next.rsp_valid    = 1'b1;
                        st_next.rsp_last     = 1'b1;
                        st_next.rsp_exc      = 1'b1;
                        st_next.rsp_exc_code = EXC_BAD_ADDR;
                        st_next.req_ready    = 1'b1;
                    end else begin
                        st_next.state   = SCD_SEND;
                        st_next.rd_addr = req_addr_i;
                        st_next.rd_left = req_qty_i;
                    end
                end
            end
            SCD_SEND: begin
                st_next.rsp_valid = 1'b1;
                st_next.rsp_data  = word_at(st_reg, st_reg.rd_addr);
                st_next.rd_addr   = st_reg.rd_addr + 16'h0001;
                st_next.rd_left   = st_reg.rd_left - 16'h0001;
                if (st_reg.rd_left == 16'h0001) begin
                    st_next.rsp_last  = 1'b1;
                    st_next.state     = SCD_IDLE;
                    st_next.req_ready = 1'b1;
                end
            end
            default: begin
                st_next.state = SCD_INIT;
            end
        endcase
        // Start-phase flag from the state about to be entered, so it is a flop
        st_next.init_busy = (st_next.state == SCD_INIT);
    end

    // State register, all zero on reset
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign req_ready_o      = st_reg.req_ready;
    assign rsp_valid_o      = st_reg.rsp_valid;
    assign rsp_data_o       = st_reg.rsp_data;
    assign rsp_last_o       = st_reg.rsp_last;
    assign rsp_exc_o        = st_reg.rsp_exc;
    assign rsp_exc_code_o   = st_reg.rsp_exc_code;
    assign contact_closed_o = st_reg.contact_closed;
    assign init_busy_o      = st_reg.init_busy;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    a_unused_bits_zero: assert property (
        st_reg.w_err[15:5] == 11'h000 && st_reg.w_high[15:4] == 12'h000
        && st_reg.w_pos[15:5] == 11'h000 && st_reg.w_cfg[15:5] == 11'h000)
        else $error("unused status bits not zero");

    a_guard_error_zero: assert property (
        (st_reg.w_err[4:1] != 4'h0) |-> (st_reg.w_low == 16'h0000))
        else $error("guard low word not zero in error mode");

    a_guard_high_zero: assert property (
        (st_reg.w_err[4:1] != 4'h0) |-> (st_reg.w_high == 16'h0000))
        else $error("guard high word not zero in error mode");

    a_contact_stays_open: assert property (
        (st_reg.state != SCD_INIT && $past(st_reg.state) != SCD_INIT
         && !st_reg.contact_closed) |=> !st_reg.contact_closed)
        else $error("contact closed again after opening");

    a_contact_bit_match: assert property (
        (st_reg.state != SCD_INIT) |=> (st_reg.w_err[0] == $past(st_reg.contact_closed)))
        else $error("contact bit does not follow contact");

    a_init_no_ready: assert property (
        (st_reg.state == SCD_INIT) |-> (!req_ready_o && !contact_closed_o))
        else $error("request or contact active in start phase");

    a_bad_func_exc: assert property (
        (req_ready_o && req_valid_i && req_func_i != FUNC_READ_HOLDING)
        |=> (rsp_exc_o && rsp_exc_code_o == EXC_BAD_FUNC && rsp_last_o))
        else $error("wrong function not refused");

    a_loop_bit_tracks: assert property (
        (st_reg.state != SCD_INIT) |=> (st_reg.w_err[4] == $past(loop_absent_s)))
        else $error("loopback bit does not follow input");

    a_cfg_word_value: assert property (
        (st_reg.state == SCD_SEND) |-> (st_reg.w_cfg == {11'h000, st_reg.cfg_count}))
        else $error("count word wrong");

    a_too_many_bit: assert property (
        (st_reg.state != SCD_INIT) |=> (st_reg.w_err[3] == ($past(seen_count_s) > 6'h14)))
        else $error("chain length bit wrong");
endmodule : scd_status_regs
`default_nettype wire

// ==== dv/scd_master_model.sv ====
// Request-side master model: issues read requests and gathers the answers
`timescale 1ns/10ps
`default_nettype none
module scd_master_model (
    input  wire logic        clock_i,
    output logic             req_valid_o,
    output logic [7:0]       req_func_o,
    output logic [15:0]      req_addr_o,
    output logic [15:0]      req_qty_o,
    input  wire logic        req_ready_i,
    input  wire logic        rsp_valid_i,
    input  wire logic [15:0] rsp_data_i,
    input  wire logic        rsp_last_i,
    input  wire logic        rsp_exc_i,
    input  wire logic [7:0]  rsp_exc_code_i
);
    logic [15:0] rd_words [0:7];
    int          rd_count;
    logic        got_exc;
    logic [7:0]  got_code;
    logic        timed_out;

    // Idle request lines at time zero
    initial begin
        req_valid_o = 1'b0;
        req_func_o  = 8'h00;
        req_addr_o  = 16'h0000;
        req_qty_o   = 16'h0000;
    end

    // One request held until taken, then answer words gathered in order
    task automatic transfer(input logic [7:0] func, input logic [15:0] addr,
                            input logic [15:0] qty);
        int n;
        rd_count  = 0;
        got_exc   = 1'b0;
        got_code  = 8'h00;
        timed_out = 1'b0;
        n         = 0;
        @(posedge clock_i);
        req_valid_o <= 1'b1;
        req_func_o  <= func;
        req_addr_o  <= addr;
        req_qty_o   <= qty;
        do begin
            @(posedge clock_i);
            n++;
        end while (req_ready_i !== 1'b1 && n < 200);
        // Released lines show garbage, not the last value
        req_valid_o <= 1'b0;
        req_func_o  <= ~func;
        req_addr_o  <= ~addr;
        req_qty_o   <= ~qty;
        timed_out = (n >= 200);
        n = 0;
        while (n < 200) begin
            @(posedge clock_i);
            n++;
            if (rsp_valid_i === 1'b1) begin
                if (rd_count < 8) begin
                    rd_words[rd_count] = rsp_data_i;
                end
                rd_count++;
                got_exc  = rsp_exc_i;
                got_code = rsp_exc_code_i;
                if (rsp_last_i === 1'b1) begin
                    break;
                end
            end
        end
        if (n >= 200) begin
            timed_out = 1'b1;
        end
    endtask : transfer
endmodule : scd_master_model
`default_nettype wire

// ==== dv/scd_status_regs_bench.sv ====
// Self-checking bench for the chain diagnostic status bank
`timescale 1ns/10ps
`default_nettype none
module scd_status_regs_bench;
    import scd_pkg::*;
    localparam int INIT_LEN = 20;
    logic        clock_i, srst_i, loop_absent, sw_fail, cab_brk, bad_tp, sticky;
    logic [5:0]  seen;
    logic [4:0]  fpos, dip, dip_cap;
    logic [19:0] guards;
    logic        req_valid, req_ready, rsp_valid, rsp_last, rsp_exc, contact, busy;
    logic [7:0]  req_func, rsp_code;
    logic [15:0] req_addr, req_qty, rsp_data, a, q;
    int          err_count, checks, seed, cnt;
    logic [7:0]  bad_funcs [0:3] = '{8'h01, 8'h04, 8'h06, 8'h10};

    scd_status_regs #(.INIT_LEN(INIT_LEN)) u_dut (
        .clock_i(clock_i), .srst_i(srst_i), .loop_absent_i(loop_absent),
        .seen_count_i(seen), .switch_fail_i(sw_fail), .cable_break_i(cab_brk),
        .bad_transponder_i(bad_tp), .fault_pos_i(fpos), .guard_closed_i(guards),
        .dip_count_i(dip), .req_valid_i(req_valid), .req_func_i(req_func),
        .req_addr_i(req_addr), .req_qty_i(req_qty), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_last_o(rsp_last),
        .rsp_exc_o(rsp_exc), .rsp_exc_code_o(rsp_code),
        .contact_closed_o(contact), .init_busy_o(busy));

    scd_master_model u_master (
        .clock_i(clock_i), .req_valid_o(req_valid), .req_func_o(req_func),
        .req_addr_o(req_addr), .req_qty_o(req_qty), .req_ready_i(req_ready),
        .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .rsp_last_i(rsp_last),
        .rsp_exc_i(rsp_exc), .rsp_exc_code_i(rsp_code));

    // Free-running 125 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    function automatic int rnd(input int n);
        return {$random(seed)} % n;
    endfunction : rnd

    // Expected error field from the current pin picture
    function automatic logic [4:0] exp_err();
        logic [4:0] e;
        e[4] = loop_absent;
        e[3] = seen > 6'h14;
        e[2] = (seen != {1'b0, dip_cap}) || (dip != dip_cap);
        e[1] = sw_fail | cab_brk | bad_tp;
        e[0] = !sticky;
        return e;
    endfunction : exp_err

    function automatic logic [15:0] exp_word(input logic [15:0] addr);
        logic [4:0] e;
        e = exp_err();
        case (addr)
            ADDR_ERR_FLAGS:  return {11'h000, e};
            ADDR_GUARD_LOW:  return (|e[4:1]) ? 16'h0000 : guards[15:0];
            ADDR_GUARD_HIGH: return (|e[4:1]) ? 16'h0000 : {12'h000, guards[19:16]};
            ADDR_FAULT_POS:  return e[1] ? {11'h000, fpos} : 16'h0000;
            default:         return {11'h000, dip_cap};
        endcase
    endfunction : exp_word

    task automatic final_report;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    // Let pins pass the synchronisers, then track the sticky contact
    task automatic settle;
        logic [4:0] e;
        repeat (6) @(posedge clock_i);
        // Only the fault bits latch the contact open, not the contact bit
        e = exp_err();
        if (|e[4:1]) sticky = 1'b1;
    endtask : settle

    task automatic clean_pins(input logic [4:0] n);
        @(posedge clock_i);
        {loop_absent, sw_fail, cab_brk, bad_tp} <= 4'h0;
        dip    <= n;
        seen   <= {1'b0, n};
        guards <= 20'(rnd(32'h100000));
        fpos   <= 5'(1 + rnd(20));
    endtask : clean_pins

    task automatic do_reset;
        srst_i <= 1'b1;
        repeat (20) @(posedge clock_i);
        srst_i <= 1'b0;
        sticky  = 1'b0;
        dip_cap = dip;
        cnt     = 0;
        @(posedge clock_i);
        cmp_bit(contact, 1'b0);
        while (req_ready !== 1'b1 && cnt < 100) begin
            @(posedge clock_i);
            cnt++;
            if (cnt == 2) cmp_bit(busy, 1'b1);
        end
        cmp_bit(cnt >= INIT_LEN - 2 && cnt <= INIT_LEN + 1, 1'b1);
    endtask : do_reset

    task automatic read_chk(input logic [15:0] addr, input logic [15:0] qty);
        u_master.transfer(FUNC_READ_HOLDING, addr, qty);
        cmp_bit(u_master.timed_out | u_master.got_exc, 1'b0);
        cmp_word(16'(u_master.rd_count), qty);
        for (int i = 0; i < qty; i++) cmp_word(u_master.rd_words[i], exp_word(addr + 16'(i)));
    endtask : read_chk

    task automatic exc_chk(input logic [7:0] f, input logic [15:0] addr,
                           input logic [15:0] qty, input logic [7:0] code);
        u_master.transfer(f, addr, qty);
        cmp_bit(u_master.got_exc, 1'b1);
        cmp_word({8'h00, u_master.got_code}, {8'h00, code});
    endtask : exc_chk

    // Watchdog against a hung handshake
    initial begin
        #300000;
        err_count++;
        final_report();
    end

    // Main sequence
    initial begin
        seed = 32'h3621;
        err_count = 0;
        checks = 0;
        srst_i = 1'b1;
        {loop_absent, sw_fail, cab_brk, bad_tp, sticky} = 5'h00;
        {seen, fpos, dip, dip_cap, guards} = '0;
        clean_pins(5'h0e);
        do_reset();
        settle();
        read_chk(ADDR_ERR_FLAGS, NUM_WORDS);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock_i);
            guards <= 20'(rnd(32'h100000));
            a = 16'(rnd(5));
            q = 16'(1 + rnd(5 - a));
            settle();
            read_chk(a, q);
        end
        for (int i = 0; i < 4; i++) exc_chk(bad_funcs[i], 16'h0000, 16'h0001, EXC_BAD_FUNC);
        exc_chk(FUNC_READ_HOLDING, 16'h0000, 16'h0000, EXC_BAD_QTY);
        exc_chk(FUNC_READ_HOLDING, 16'h0000, 16'h007e, EXC_BAD_QTY);
        exc_chk(FUNC_READ_HOLDING, 16'h0004, 16'h0002, EXC_BAD_ADDR);
        exc_chk(FUNC_READ_HOLDING, 16'h0005, 16'h0001, EXC_BAD_ADDR);
        // One fault at a time, then cleared: the contact stays open
        for (int k = 0; k < 7; k++) begin
            clean_pins(5'h0e);
            @(posedge clock_i);
            case (k)
                0: loop_absent <= 1'b1;
                1: seen <= 6'h15;
                2: seen <= 6'h0d;
                3: sw_fail <= 1'b1;
                4: cab_brk <= 1'b1;
                5: bad_tp <= 1'b1;
                default: dip <= 5'h0f;
            endcase
            settle();
            read_chk(ADDR_ERR_FLAGS, NUM_WORDS);
            clean_pins(5'h0e);
            settle();
            read_chk(ADDR_ERR_FLAGS, NUM_WORDS);
            cmp_bit(contact, 1'b0);
        end
        // Second reset at the full chain length closes the contact again
        clean_pins(5'h14);
        @(posedge clock_i);
        guards <= 20'hfffff;
        do_reset();
        settle();
        read_chk(ADDR_ERR_FLAGS, NUM_WORDS);
        cmp_bit(contact, 1'b1);
        final_report();
    end
endmodule : scd_status_regs_bench
`default_nettype wire
